// ### rxopc_consts.svh
`ifndef RXOPC_CONSTS_SVH
`define RXOPC_CONSTS_SVH

// Register offsets (byte addresses, one 32-bit word each)
`define RXOPC_OFF_OPMODE 8'h00
`define RXOPC_OFF_DESC_BASE 8'h04
`define RXOPC_OFF_STATUS 8'h08
`define RXOPC_OFF_MASK 8'h0c
`define RXOPC_OFF_CUR_DESC 8'h10
`define RXOPC_OFF_CFG 8'h14

// Operation mode field positions
`define RXOPC_BIT_FEF 7
`define RXOPC_BIT_FUF 6
`define RXOPC_BIT_RTC_HI 4
`define RXOPC_BIT_RTC_LO 3
`define RXOPC_BIT_OSF 2
`define RXOPC_BIT_SR 1
`define RXOPC_OPMODE_WMASK 32'h0000_00de

// Own config register: store-and-forward, rx state readback
`define RXOPC_BIT_RSF 0
`define RXOPC_BIT_STATE_LO 8

// Event flag positions
`define RXOPC_EV_OVF 4
`define RXOPC_EV_RX_FRAME 6
`define RXOPC_EV_RBU 7
`define RXOPC_EV_RX_STOP 8
`define RXOPC_EV_MASK 32'h0000_01d0

// Reset values
`define RXOPC_RST_OPMODE 32'h0000_0000
`define RXOPC_RST_WORD 32'h0000_0000

// Frame sizes and receive thresholds in bytes
`define RXOPC_MIN_FRAME 8'h40
`define RXOPC_THR_00 8'h40
`define RXOPC_THR_01 8'h20
`define RXOPC_THR_10 8'h60
`define RXOPC_THR_11 8'h80

// Descriptor stride in bytes
`define RXOPC_DESC_STEP 32'h0000_0010

`endif

// ### rxopc_pkg.sv
package rxopc_pkg;

    // Receive DMA process states
    typedef enum logic [1:0] {
        RX_STOPPED,
        RX_RUN_WAIT,
        RX_RUN_XFER,
        RX_SUSPENDED
    } rxopc_rx_state_t;

    // Frame error status, one bit per cause
    typedef struct packed {
        logic crc;
        logic coll;
        logic gmii;
        logic giant;
        logic wdt;
        logic ovf;
    } rxopc_err_t;

endpackage

// ### rxopc_thresh.sv
`timescale 1ns/1ps
`include "rxopc_consts.svh"

// Threshold level decode and fill comparisons
module rxopc_thresh #(
    parameter int CNT_W = 14
) (
    // Settings
    input wire logic [1:0] rtc_i,
    input wire logic rsf_i,
    // Bytes of the current frame
    input wire logic [CNT_W-1:0] cnt_i,
    // Results
    output logic [7:0] thr_o,
    output logic thr_hit_o,
    output logic short_o
);

    // Code to byte level
    always_comb
    begin
        case (rtc_i)
            2'h0: thr_o = `RXOPC_THR_00;
            2'h1: thr_o = `RXOPC_THR_01;
            2'h2: thr_o = `RXOPC_THR_10;
            default: thr_o = `RXOPC_THR_11;
        endcase
    end

    // Level ignored entirely in store-and-forward
    assign thr_hit_o = !rsf_i && (cnt_i > CNT_W'(thr_o));
    // Undersized: below minimum, pad and CRC counted
    assign short_o = cnt_i < CNT_W'(`RXOPC_MIN_FRAME);

endmodule

// ### rxopc_filter.sv
`timescale 1ns/1ps

// Drop or forward decision at end of frame
module rxopc_filter (
    // Settings
    input wire logic fef_i,
    input wire logic fuf_i,
    // Frame facts
    input wire rxopc_pkg::rxopc_err_t err_i,
    input wire logic runt_i,
    input wire logic short_i,
    input wire logic partial_ovf_i,
    input wire logic committed_i,
    // Decision
    output logic drop_o
);

    logic any_err;

    assign any_err = |err_i;

    // Already-started frames cannot be recalled, so they always pass
    always_comb
    begin
        if (committed_i)
            drop_o = 1'b0;
        else if (partial_ovf_i)
            drop_o = 1'b1;
        else if (runt_i)
            drop_o = 1'b1;
        else if (any_err)
            drop_o = !fef_i;
        else
            drop_o = short_i && !fuf_i;
    end

endmodule

// ### rxopc_top.sv
`timescale 1ns/1ps
`include "rxopc_consts.svh"

// What this block does
// - Drop error frames unless error forwarding set
// - Frames already handed over are never dropped
// - Error forwarding passes all error frames but runt and partly written overflow ones
// - Partly written overflow frames dropped unless already started
// - Undersized forwarding passes short good frames
// - Otherwise short frames dropped unless already started
// - Threshold code picks level; exceed starts request
// - Complete frames below threshold transfer automatically
// - Threshold ignored while store-and-forward set
// - Second-frame option lets transmit start early
// - Start runs, fetching from base or retained
// - No owned descriptor suspends, flags bit 7
// - Start acts only when stopped
// - Stop waits for current frame, keeps position
// - Stop acts only when running or suspended
module rxopc_top #(
    parameter int CNT_W = 14
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Frame write side of the receive FIFO
    input wire logic frm_sof_i,
    input wire logic frm_byte_i,
    input wire logic frm_eof_i,
    input wire rxopc_pkg::rxopc_err_t frm_err_i,
    input wire logic frm_runt_i,
    input wire logic frm_partial_ovf_i,
    // Frame verdicts and DMA request
    output logic frm_fwd_o,
    output logic frm_drop_o,
    output logic rd_req_o,
    // Receive DMA descriptor side
    input wire logic desc_owned_i,
    input wire logic xfer_done_i,
    output logic desc_fetch_o,
    output logic [31:0] desc_addr_o,
    output rxopc_pkg::rxopc_rx_state_t rx_state_o,
    // Transmit DMA side
    input wire logic tx_status_pending_i,
    output logic tx_next_ok_o,
    // Interrupt
    output logic irq_o
);

    // Block state, all but the reset synchroniser, in one record
    typedef struct packed {
        logic [31:0] opmode;
        logic [31:0] base;
        logic [31:0] cur;
        logic [31:0] status;
        logic [31:0] mask;
        logic rx_store_forward_en;
        logic reload;
        logic start_pend;
        rxopc_pkg::rxopc_rx_state_t st;
        logic in_frame;
        logic committed;
        logic [CNT_W-1:0] cnt;
        logic rd_req;
        logic fwd;
        logic drop;
        logic fetch;
        logic tx_ok;
        logic irq;
        logic [31:0] rdata;
    } rxopc_top_state_t;

    rxopc_top_state_t s_q;
    rxopc_top_state_t s_d;
    logic [1:0] rst_sync_q; // Reset release synchroniser
    logic rst_n;
    logic [7:0] thr; // Active threshold level
    logic thr_hit;
    logic short_frm;
    logic drop_now;
    logic sr_bit;

    // Async assert, synchronous release
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];
    assign sr_bit = s_q.opmode[`RXOPC_BIT_SR];

    // Threshold level and comparisons
    rxopc_thresh #(.CNT_W(CNT_W)) u_thresh (
        .rtc_i(s_q.opmode[`RXOPC_BIT_RTC_HI:`RXOPC_BIT_RTC_LO]),
        .rsf_i(s_q.rx_store_forward_en),
        .cnt_i(s_q.cnt),
        .thr_o(thr),
        .thr_hit_o(thr_hit),
        .short_o(short_frm)
    );

    // End of frame verdict
    rxopc_filter u_filter (
        .fef_i(s_q.opmode[`RXOPC_BIT_FEF]),
        .fuf_i(s_q.opmode[`RXOPC_BIT_FUF]),
        .err_i(frm_err_i),
        .runt_i(frm_runt_i),
        .short_i(short_frm),
        .partial_ovf_i(frm_partial_ovf_i),
        .committed_i(s_q.committed),
        .drop_o(drop_now)
    );

    // Next-state logic for everything
    always_comb
    begin
        s_d = s_q;
        s_d.fwd = 1'b0;
        s_d.drop = 1'b0;
        s_d.fetch = 1'b0;
        s_d.rdata = 32'h0000_0000;
        // Register writes
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `RXOPC_OFF_OPMODE:
                begin
                    s_d.opmode = reg_wdata_i & `RXOPC_OPMODE_WMASK;
                    // Start request counts only when stopped
                    if (reg_wdata_i[`RXOPC_BIT_SR] && s_q.st == rxopc_pkg::RX_STOPPED)
                        s_d.start_pend = 1'b1;
                end
                `RXOPC_OFF_DESC_BASE:
                begin
                    s_d.base = reg_wdata_i;
                    s_d.reload = 1'b1;
                end
                `RXOPC_OFF_STATUS:
                    s_d.status = s_q.status & ~reg_wdata_i;
                `RXOPC_OFF_MASK:
                    s_d.mask = reg_wdata_i & `RXOPC_EV_MASK;
                `RXOPC_OFF_CFG:
                    s_d.rx_store_forward_en = reg_wdata_i[`RXOPC_BIT_RSF];
                default:
                    s_d.rx_store_forward_en = s_q.rx_store_forward_en;
            endcase
        end

        // Register reads, data in the next cycle
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `RXOPC_OFF_OPMODE:
                    s_d.rdata = s_q.opmode;
                `RXOPC_OFF_DESC_BASE:
                    s_d.rdata = s_q.base;
                `RXOPC_OFF_STATUS:
                    s_d.rdata = s_q.status;
                `RXOPC_OFF_MASK:
                    s_d.rdata = s_q.mask;
                `RXOPC_OFF_CUR_DESC:
                    s_d.rdata = s_q.cur;
                `RXOPC_OFF_CFG:
                    s_d.rdata = {22'h0, s_q.st, 7'h0, s_q.rx_store_forward_en};
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Frame byte counting, saturating on giants
        if (frm_sof_i)
        begin
            s_d.in_frame = 1'b1;
            s_d.committed = 1'b0;
            s_d.cnt = '0;
        end
        else if (s_q.in_frame && frm_byte_i && s_q.cnt != '1)
            s_d.cnt = s_q.cnt + CNT_W'(1);
        // Crossing the level hands the frame to the read side
        if (s_q.in_frame && !frm_eof_i && thr_hit && !s_q.committed)
        begin
            s_d.committed = 1'b1;
            s_d.rd_req = 1'b1;
        end
        // End of frame: committed frames pass else filter
        if (s_q.in_frame && frm_eof_i)
        begin
            s_d.in_frame = 1'b0;
            s_d.committed = 1'b0;
            s_d.fwd = !drop_now;
            s_d.drop = drop_now;
            // Whole frame below the level goes without a crossing
            if (!drop_now)
                s_d.rd_req = 1'b1;
        end
        // DMA finished reading the frame
        if (xfer_done_i)
            s_d.rd_req = 1'b0;
        // Receive DMA process
        case (s_q.st)
            rxopc_pkg::RX_STOPPED:
            begin
                // Fetch from base when reprogrammed, else retained spot
                if (s_q.start_pend)
                begin
                    s_d.start_pend = 1'b0;
                    s_d.st = rxopc_pkg::RX_RUN_WAIT;
                    s_d.fetch = 1'b1;
                    if (s_q.reload)
                    begin
                        s_d.cur = s_q.base;
                        s_d.reload = 1'b0;
                    end
                end
            end
            rxopc_pkg::RX_RUN_WAIT:
            begin
                // Stop honoured while idle-running
                if (!sr_bit)
                begin
                    s_d.st = rxopc_pkg::RX_STOPPED;
                    s_d.status[`RXOPC_EV_RX_STOP] = 1'b1;
                end
                else if (!desc_owned_i)
                begin
                    // Nothing owned: park and flag buffer unavailable
                    s_d.st = rxopc_pkg::RX_SUSPENDED;
                    s_d.status[`RXOPC_EV_RBU] = 1'b1;
                end
                else if (s_q.rd_req)
                    s_d.st = rxopc_pkg::RX_RUN_XFER;
            end
            rxopc_pkg::RX_RUN_XFER:
            begin
                // Stop deferred to frame end, next position kept
                if (xfer_done_i)
                begin
                    s_d.cur = s_q.cur + `RXOPC_DESC_STEP;
                    if (!sr_bit)
                    begin
                        s_d.st = rxopc_pkg::RX_STOPPED;
                        s_d.status[`RXOPC_EV_RX_STOP] = 1'b1;
                    end
                    else
                        s_d.st = rxopc_pkg::RX_RUN_WAIT;
                end
            end
            rxopc_pkg::RX_SUSPENDED:
            begin
                // Stop honoured while suspended
                if (!sr_bit)
                begin
                    s_d.st = rxopc_pkg::RX_STOPPED;
                    s_d.status[`RXOPC_EV_RX_STOP] = 1'b1;
                end
                else if (desc_owned_i)
                    s_d.st = rxopc_pkg::RX_RUN_WAIT;
            end
            default:
                s_d.st = rxopc_pkg::RX_STOPPED;
        endcase

        // Other sticky events; set applied after the clear so set wins
        if (s_q.in_frame && frm_eof_i)
        begin
            if (!drop_now)
                s_d.status[`RXOPC_EV_RX_FRAME] = 1'b1;
            if (frm_err_i.ovf || frm_partial_ovf_i)
                s_d.status[`RXOPC_EV_OVF] = 1'b1;
        end

        // Transmit may open another frame early
        s_d.tx_ok = s_q.opmode[`RXOPC_BIT_OSF] || !tx_status_pending_i;
        // Level interrupt from unmasked flags
        s_d.irq = |(s_d.status & s_q.mask);
    end

    // All state registered; reset clears every control field
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.opmode <= `RXOPC_RST_OPMODE;
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from flops
    assign reg_rdata_o = s_q.rdata;
    assign frm_fwd_o = s_q.fwd;
    assign frm_drop_o = s_q.drop;
    assign rd_req_o = s_q.rd_req;
    assign desc_fetch_o = s_q.fetch;
    assign desc_addr_o = s_q.cur;
    assign rx_state_o = s_q.st;
    assign tx_next_ok_o = s_q.tx_ok;
    assign irq_o = s_q.irq;

    // Checks on the block's own outputs
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    a_err_frame_drop: assert property (
        s_q.in_frame && frm_eof_i && !s_q.committed && (|frm_err_i) && !s_q.opmode[`RXOPC_BIT_FEF]
        |=> frm_drop_o && !frm_fwd_o)
        else $error("error frame not dropped");
    a_committed_pass: assert property (
        s_q.in_frame && frm_eof_i && s_q.committed |=> frm_fwd_o && rd_req_o)
        else $error("handed-over frame dropped");
    a_fef_forward: assert property (
        s_q.in_frame && frm_eof_i && !s_q.committed && s_q.opmode[`RXOPC_BIT_FEF] && !frm_runt_i
        && !frm_partial_ovf_i && (|frm_err_i) |=> frm_fwd_o)
        else $error("error frame not forwarded");
    a_partial_drop: assert property (
        s_q.in_frame && frm_eof_i && !s_q.committed && frm_partial_ovf_i |=> frm_drop_o)
        else $error("partial overflow frame passed");
    a_short_good: assert property (
        s_q.in_frame && frm_eof_i && !s_q.committed && short_frm && !(|frm_err_i) && !frm_runt_i
        && !frm_partial_ovf_i |=> frm_fwd_o == $past(s_q.opmode[`RXOPC_BIT_FUF]))
        else $error("undersized good frame mishandled");
    a_level_request: assert property (
        s_q.in_frame && !frm_eof_i && !s_q.rx_store_forward_en && s_q.cnt > CNT_W'(thr) |=> rd_req_o)
        else $error("threshold crossing gave no request");
    a_small_auto: assert property (
        s_q.in_frame && frm_eof_i && !drop_now |=> rd_req_o ##0 frm_fwd_o)
        else $error("complete frame not requested");
    a_rsf_no_early: assert property (
        s_q.rx_store_forward_en && s_q.in_frame && !frm_eof_i && !s_q.rd_req && !xfer_done_i |=> !rd_req_o)
        else $error("threshold used in store-and-forward");
    a_osf_tx: assert property (
        s_q.opmode[`RXOPC_BIT_OSF] |=> tx_next_ok_o)
        else $error("second frame held back");
    a_start_fetch: assert property (
        desc_fetch_o |-> $past(s_q.st) == rxopc_pkg::RX_STOPPED && rx_state_o == rxopc_pkg::RX_RUN_WAIT)
        else $error("fetch outside a start");
    a_rbu_suspend: assert property (
        s_q.st == rxopc_pkg::RX_RUN_WAIT && sr_bit && !desc_owned_i
        |=> rx_state_o == rxopc_pkg::RX_SUSPENDED && s_q.status[`RXOPC_EV_RBU])
        else $error("no suspend on missing descriptor");
    a_stop_deferred: assert property (
        s_q.st == rxopc_pkg::RX_RUN_XFER && !xfer_done_i |=> rx_state_o != rxopc_pkg::RX_STOPPED)
        else $error("stop cut a frame short");
    a_stop_idle: assert property (
        (s_q.st == rxopc_pkg::RX_RUN_WAIT || s_q.st == rxopc_pkg::RX_SUSPENDED) && !sr_bit
        |=> rx_state_o == rxopc_pkg::RX_STOPPED ##1 rx_state_o == rxopc_pkg::RX_STOPPED || s_q.start_pend)
        else $error("stop not taken when idle");

    c_threshold_frame: cover property (s_q.committed && frm_eof_i);
    c_suspend_resume: cover property (
        rx_state_o == rxopc_pkg::RX_SUSPENDED ##[1:20] rx_state_o == rxopc_pkg::RX_RUN_WAIT);
    c_stop_after_xfer: cover property (
        rx_state_o == rxopc_pkg::RX_RUN_XFER && !sr_bit ##[1:50] rx_state_o == rxopc_pkg::RX_STOPPED);
    c_drop_seen: cover property (frm_drop_o);

endmodule

// ### rxopc_dma_model.sv
`timescale 1ns/1ps

// Receive DMA stand-in: owns descriptors on demand, finishes transfers late
module rxopc_dma_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bench controls
    input wire logic owned_en_i,
    input wire logic hold_i,
    input wire logic [7:0] delay_i,
    // Block side
    input wire rxopc_pkg::rxopc_rx_state_t rx_state_i,
    output logic desc_owned_o,
    output logic xfer_done_o
);
    logic [7:0] cnt_q; // Cycles spent in this transfer
    logic done_q; // One completion per transfer

    // Ownership is a plain level set by the bench
    assign desc_owned_o = owned_en_i;

    // Completion only after the delay and never while held, so slow answers are seen
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 8'h00;
            done_q <= 1'b0;
            xfer_done_o <= 1'b0;
        end
        else
        begin
            xfer_done_o <= 1'b0;
            if (rx_state_i != rxopc_pkg::RX_RUN_XFER)
            begin
                cnt_q <= 8'h00;
                done_q <= 1'b0;
            end
            else if (!hold_i && !done_q)
            begin
                if (cnt_q >= delay_i)
                begin
                    xfer_done_o <= 1'b1;
                    done_q <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
`include "rxopc_consts.svh"

// Self-checking bench: registers, frame verdicts, thresholds, DMA states
module tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic frm_sof_i = 1'b0, frm_byte_i = 1'b0, frm_eof_i = 1'b0;
    logic frm_runt_i = 1'b0, frm_partial_ovf_i = 1'b0, tx_status_pending_i = 1'b0;
    rxopc_pkg::rxopc_err_t frm_err_i = '0;
    logic [31:0] reg_rdata_o, desc_addr_o;
    logic frm_fwd_o, frm_drop_o, rd_req_o, desc_owned_i, xfer_done_i, desc_fetch_o, tx_next_ok_o, irq_o;
    rxopc_pkg::rxopc_rx_state_t rx_state_o;
    logic owned_en = 1'b0, hold = 1'b0, rx_store_forward_en = 1'b0;
    logic [31:0] rd_v, exp_addr, r;
    int err_total = 0, checks = 0, cycles = 0, seed = 32'h5afe, n, k;

    rxopc_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .frm_sof_i(frm_sof_i),
        .frm_byte_i(frm_byte_i), .frm_eof_i(frm_eof_i), .frm_err_i(frm_err_i), .frm_runt_i(frm_runt_i),
        .frm_partial_ovf_i(frm_partial_ovf_i), .frm_fwd_o(frm_fwd_o), .frm_drop_o(frm_drop_o),
        .rd_req_o(rd_req_o), .desc_owned_i(desc_owned_i), .xfer_done_i(xfer_done_i),
        .desc_fetch_o(desc_fetch_o), .desc_addr_o(desc_addr_o), .rx_state_o(rx_state_o),
        .tx_status_pending_i(tx_status_pending_i), .tx_next_ok_o(tx_next_ok_o), .irq_o(irq_o));

    rxopc_dma_model dma (.clk_i(clk_i), .rst_n_i(rst_n_i), .owned_en_i(owned_en), .hold_i(hold),
        .delay_i(8'h03), .rx_state_i(rx_state_o), .desc_owned_o(desc_owned_i), .xfer_done_o(xfer_done_i));

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    // Hang guard, well above the expected run length
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_total++;
            results();
        end
    end

    // Verdict and end of run
    task results;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Settle past the edge updates
    task step(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask

    // One-cycle register write
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // One-cycle register read, data taken in the following cycle only
    task rd(input logic [7:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        rd_v = reg_rdata_o;
    endtask

    // Threshold level in bytes for a code
    function automatic int thr(input logic [1:0] c);
        case (c)
            2'b00: return `RXOPC_THR_00;
            2'b01: return `RXOPC_THR_01;
            2'b10: return `RXOPC_THR_10;
            default: return `RXOPC_THR_11;
        endcase
    endfunction

    // Full frame, with DMA held until after the verdict
    task frame(input int len, input rxopc_pkg::rxopc_err_t e, input logic runt, input logic povf,
        input logic fef, input logic forward_undersized_good_en, input logic [1:0] rtc, input logic stop);
        logic com, drop;
        int i;
        wr(`RXOPC_OFF_OPMODE, {24'h0, fef, forward_undersized_good_en, 1'b0, rtc, 3'b010});
        com = !rx_store_forward_en && len > thr(rtc);
        drop = !com && (runt || povf || (e != '0 && !fef) || (len < 64 && e == '0 && !forward_undersized_good_en));
        @(posedge clk_i);
        hold <= 1'b1;
        frm_sof_i <= 1'b1;
        for (i = 0; i < len; i++)
        begin
            @(posedge clk_i);
            frm_sof_i <= 1'b0;
            frm_byte_i <= 1'b1;
        end
        @(posedge clk_i);
        frm_byte_i <= 1'b0;
        step(2);
        chk(rd_req_o, com);
        @(posedge clk_i);
        frm_eof_i <= 1'b1;
        frm_err_i <= e;
        frm_runt_i <= runt;
        frm_partial_ovf_i <= povf;
        @(posedge clk_i);
        frm_eof_i <= 1'b0;
        frm_err_i <= '0;
        frm_runt_i <= 1'b0;
        frm_partial_ovf_i <= 1'b0;
        #1;
        chk({frm_drop_o, frm_fwd_o}, {drop, !drop});
        if (!drop)
            exp_addr = exp_addr + `RXOPC_DESC_STEP;
        if (stop)
        begin
            wr(`RXOPC_OFF_OPMODE, 32'h0000_0000);
            step(3);
            chk(rx_state_o, rxopc_pkg::RX_RUN_XFER);
        end
        @(posedge clk_i);
        hold <= 1'b0;
        for (i = 0; i < 100 && (rd_req_o !== 1'b0 || rx_state_o === rxopc_pkg::RX_RUN_XFER); i++)
            step(1);
        step(1);
        chk(rx_state_o, stop ? rxopc_pkg::RX_STOPPED : rxopc_pkg::RX_RUN_WAIT);
        chk(desc_addr_o, exp_addr);
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        step(5);
        rd(`RXOPC_OFF_OPMODE);
        chk(rd_v, `RXOPC_RST_OPMODE);
        rd(`RXOPC_OFF_CFG);
        chk(rd_v, `RXOPC_RST_WORD);
        rd(`RXOPC_OFF_STATUS);
        chk(rd_v, `RXOPC_RST_WORD);
        rd(8'h1c);
        chk(rd_v, 32'h0000_0000);
        chk(rx_state_o, rxopc_pkg::RX_STOPPED);
        $display("test reset done");
        // Start with no owned descriptor: suspend and flag, then the interrupt path
        exp_addr = 32'h0000_1000;
        wr(`RXOPC_OFF_MASK, 32'h0000_0080);
        wr(`RXOPC_OFF_DESC_BASE, exp_addr);
        wr(`RXOPC_OFF_OPMODE, 32'h0000_0002);
        // Fetch pulse stands only in the second cycle after the write
        step(1);
        chk(desc_fetch_o, 1'b1);
        chk(desc_addr_o, exp_addr);
        step(1);
        chk(rx_state_o, rxopc_pkg::RX_SUSPENDED);
        rd(`RXOPC_OFF_STATUS);
        chk(rd_v & 32'h0000_0080, 32'h0000_0080);
        chk(irq_o, 1'b1);
        wr(`RXOPC_OFF_MASK, 32'h0000_0000);
        step(2);
        chk(irq_o, 1'b0);
        wr(`RXOPC_OFF_MASK, 32'h0000_0080);
        step(2);
        chk(irq_o, 1'b1);
        wr(`RXOPC_OFF_STATUS, 32'h0000_0080);
        step(2);
        chk(irq_o, 1'b0);
        @(posedge clk_i);
        owned_en <= 1'b1;
        step(3);
        chk(rx_state_o, rxopc_pkg::RX_RUN_WAIT);
        // Start again while running has no effect
        wr(`RXOPC_OFF_OPMODE, 32'h0000_0002);
        for (k = 0; k < 4; k++)
        begin
            step(1);
            chk(desc_fetch_o, 1'b0);
        end
        $display("test start and suspend done");
        // Threshold boundaries with an error frame
        for (k = 0; k < 4; k++)
        begin
            frame(thr(k[1:0]), 6'h20, 1'b0, 1'b0, 1'b0, 1'b0, k[1:0], 1'b0);
            frame(thr(k[1:0]) + 1, 6'h20, 1'b0, 1'b0, 1'b0, 1'b0, k[1:0], 1'b0);
        end
        // Random frames; code 11 is legal as this FIFO is larger than 128 bytes
        for (n = 0; n < 30; n++)
        begin
            r = $random(seed);
            rx_store_forward_en = r[15];
            wr(`RXOPC_OFF_CFG, {31'h0, rx_store_forward_en});
            k = 20 + r[23:16] % 130;
            if (r[0] && k < 64)
                k = k + 64;
            frame(k, r[0] ? r[6:1] : 6'h00, r[14] && k < 64, r[13:11] == 3'b000,
                r[7], r[8], r[10:9], 1'b0);
        end
        $display("test frames done");
        // Stop in mid-transfer, then restart from the kept position
        rx_store_forward_en = 1'b0;
        wr(`RXOPC_OFF_CFG, 32'h0000_0000);
        frame(40, 6'h00, 1'b0, 1'b0, 1'b0, 1'b1, 2'b00, 1'b1);
        rd(`RXOPC_OFF_STATUS);
        chk(rd_v[8], 1'b1);
        wr(`RXOPC_OFF_STATUS, `RXOPC_EV_MASK);
        wr(`RXOPC_OFF_OPMODE, 32'h0000_0000);
        step(3);
        rd(`RXOPC_OFF_STATUS);
        chk(rd_v[8], 1'b0);
        wr(`RXOPC_OFF_OPMODE, 32'h0000_0002);
        step(1);
        chk(desc_fetch_o, 1'b1);
        chk(desc_addr_o, exp_addr);
        $display("test stop and restart done");
        // Second-frame option against pending transmit status
        for (k = 0; k < 4; k++)
        begin
            wr(`RXOPC_OFF_OPMODE, {29'h0, k[0], 2'b10});
            @(posedge clk_i);
            tx_status_pending_i <= k[1];
            step(3);
            chk(tx_next_ok_o, k[0] | !k[1]);
        end
        $display("test second frame done");
        results();
    end
endmodule
